//--- tb/sipe_sensor.sv
// sipe_sensor.sv: sensors wired to the eight ports
// assumes each channel's sensor is powered by its supply output
`timescale 1ns/1ps
module sipe_sensor (
   // supplies from the block
   input  wire logic [7:0] supply_a_on,
   input  wire logic [7:0] supply_b_on,
   // levels the sensors would report
   input  wire logic [7:0] lvl_a,
   input  wire logic [7:0] lvl_b,
   // channels into the block
   output wire logic [7:0] in_a,
   output wire logic [7:0] in_b
);
   assign in_a = lvl_a & supply_a_on;
   assign in_b = lvl_b & supply_b_on;
endmodule // sipe_sensor

//--- tb/sipe_top_bench.sv
// sipe_top_bench.sv: self-checking bench for sipe_top
// assumes sipe_sensor on the ports and sipe_monitor bound in
`timescale 1ns/1ps
module sipe_top_bench;
   logic        aclk = 1'h0;
   logic        aresetn = 1'h0;
   logic [7:0]  awaddr = 8'h0, araddr = 8'h0, lvl_a = 8'h0, lvl_b = 8'h0;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic        arvalid = 1'h0, rready = 1'h0;
   logic [31:0] wdata = 32'h0, d, e;
   logic [3:0]  wstrb = 4'hf;
   logic [1:0]  r;
   logic [15:0] m;
   logic [7:0]  v;
   wire         awready, wready, bvalid, arready, rvalid;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire  [7:0]  in_a, in_b, supply_a_on, supply_b_on;
   wire  [15:0] in_status, in_valid;
   integer      errors = 0, n_compared = 0, cyc = 0, i, k;

   always #10 aclk = ~aclk;

   sipe_top uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
      .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
      .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .in_a, .in_b,
      .supply_a_on, .supply_b_on, .in_status, .in_valid);
   sipe_sensor u_sens (.supply_a_on, .supply_b_on, .lvl_a, .lvl_b, .in_a,
      .in_b);

   task summarize;
      if (errors == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         errors = errors + 1;
         summarize;
      end
   end

   task chk(input logic [33:0] g, input logic [33:0] e);
      n_compared = n_compared + 1;
      if (g !== e) begin
         errors = errors + 1;
         $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
      end
   endtask

   task wr(input logic [7:0] ad, input logic [31:0] dt,
           output logic [1:0] rs);
      awaddr <= ad;
      wdata <= dt;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      do begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'h0;
         if (wready)
            wvalid <= 1'h0;
      end while ((awvalid && !awready) || (wvalid && !wready));
      bready <= 1'h1;
      do @(posedge aclk); while (!bvalid);
      rs = bresp;
      bready <= 1'h0;
   endtask

   task rd(input logic [7:0] ad, output logic [31:0] dt,
           output logic [1:0] rs);
      araddr <= ad;
      arvalid <= 1'h1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'h0;
      rready <= 1'h1;
      do @(posedge aclk); while (!rvalid);
      dt = rdata;
      rs = rresp;
      rready <= 1'h0;
   endtask

   // status and validity of all ports
   function automatic [31:0] exp_f(input [15:0] md, input [7:0] vl, a, b);
      reg [15:0] s, l;
      reg        ok;
      integer    p;
      for (p = 0; p < 8; p++) begin
         ok = vl[p] ? a[p] ^ b[p] : a[p] ~^ b[p];
         s[2*p+:2] = md[2*p] ? {2{ok & a[p]}} : {b[p], a[p]};
         l[2*p+:2] = md[2*p] ? {2{ok}} : 2'h3;
      end
      return {l, s};
   endfunction

   initial begin
      void'($urandom(32'h2560_eaf9));
      repeat (10) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      rd(8'h00, d, r);
      chk({r, d}, 34'h0);
      rd(8'h04, d, r);
      chk({r, d}, 34'h0);
      rd(8'h10, d, r);
      chk({r, d}, 34'h1);
      wr(8'h14, 32'h0, r);
      chk({32'h0, r}, 34'h0);
      rd(8'h14, d, r);
      chk({r, d}, 34'hffff);
      rd(8'h18, d, r);
      chk({r, d}, 34'h2_0000_0000);
      wr(8'h18, 32'h0, r);
      chk({32'h0, r}, 34'h2);
      wr(8'h10, 32'h3, r);
      rd(8'h10, d, r);
      chk({r, d}, 34'h3);
      wr(8'h10, 32'h1, r);
      for (i = 0; i < 60; i++) begin
         m = (i < 2) ? 16'h5555 : 16'($urandom);
         v = (i == 1) ? 8'hff : (i == 0) ? 8'h00 : 8'($urandom);
         wr(8'h00, {16'h0, m}, r);
         wr(8'h04, {24'h0, v}, r);
         for (k = 0; k < 3; k++) begin
            lvl_a <= (k == 0) ? 8'hff : 8'($urandom);
            lvl_b <= (k == 0) ? {8{~i[0]}} : 8'($urandom);
            @(posedge aclk);
            @(posedge aclk);
            e = exp_f(m, v, lvl_a, lvl_b);
            chk({in_valid, in_status}, {2'h0, e});
            chk({supply_b_on, supply_a_on}, 34'hffff);
            if (k == 0) begin
               rd(8'h08, d, r);
               chk({r, d}, {18'h0, e[15:0]});
               rd(8'h0c, d, r);
               chk({r, d}, {18'h0, e[31:16]});
            end
         end
      end
      wr(8'h10, 32'h0, r);
      lvl_a <= 8'hff;
      lvl_b <= 8'hff;
      @(posedge aclk);
      @(posedge aclk);
      chk({in_valid, in_status}, 34'h0);
      rd(8'h08, d, r);
      chk({r, d}, 34'h0);
      summarize;
   end
endmodule // sipe_top_bench

//--- tb/sipe_top_monitor.sv
// sipe_top_monitor.sv: port assertions for sipe_top
// assumes one clock, aresetn synchronous active low
`timescale 1ns/1ps
module sipe_monitor (
   // clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // axi4-lite
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic [31:0] rdata,
   input wire logic        rvalid,
   input wire logic        rready,
   // sensor side and status
   input wire logic [7:0]  in_a,
   input wire logic [7:0]  supply_a_on,
   input wire logic [7:0]  supply_b_on,
   input wire logic [15:0] in_status,
   input wire logic [15:0] in_valid
);
   logic [20:0] age_q;
   logic [15:0] low_q;
   logic [7:0]  st_ev;
   logic [7:0]  vl_ev;
   logic [7:0]  vl_od;
   // cycles since reset and length of a supply dip
   always @(posedge aclk) begin
      if (!aresetn)
         age_q <= 21'h0;
      else if (age_q != 21'h1f_ffff)
         age_q <= age_q + 21'h1;
      if (!aresetn || supply_a_on == 8'hff)
         low_q <= 16'h0;
      else
         low_q <= low_q + 16'h1;
   end
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         st_ev[i] = in_status[2*i];
         vl_ev[i] = in_valid[2*i];
         vl_od[i] = in_valid[2*i+1];
      end
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_wr_take; awvalid && awready && wvalid && wready; endsequence
   sequence s_rd_take; arvalid && arready; endsequence
   property p_rst; $rose(aresetn) |-> in_status == 16'h0 &&
      in_valid == 16'h0 && supply_a_on == 8'hff; endproperty
   property p_st_valid; (in_status & ~in_valid) == 16'h0; endproperty
   property p_pair; supply_a_on == supply_b_on; endproperty
   property p_mirror; vl_ev == vl_od; endproperty
   property p_st_a; (st_ev & ~$past(in_a)) == 8'h0; endproperty
   property p_early; age_q < 21'h18_6a00 |-> supply_a_on == 8'hff;
   endproperty
   property p_len; supply_a_on != 8'hff |-> low_q < 16'h61a8; endproperty
   property p_b_hold; bvalid && !bready |=> bvalid; endproperty
   property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata);
   endproperty
   property p_wr; s_wr_take |-> ##[1:3] bvalid; endproperty
   property p_rd; s_rd_take |-> ##2 rvalid; endproperty
   a_rst: assert property (p_rst)
      else $error("outputs not at reset state");
   a_st_valid: assert property (p_st_valid)
      else $error("status high while invalid");
   a_pair: assert property (p_pair)
      else $error("port supplies differ");
   a_mirror: assert property (p_mirror)
      else $error("validity not mirrored");
   a_st_a: assert property (p_st_a)
      else $error("status high without input");
   a_early: assert property (p_early)
      else $error("pulse before first slot");
   a_len: assert property (p_len)
      else $error("pulse too long");
   a_b_hold: assert property (p_b_hold)
      else $error("write response dropped");
   a_r_hold: assert property (p_r_hold)
      else $error("read data dropped");
   a_wr: assert property (p_wr)
      else $error("write response late");
   a_rd: assert property (p_rd)
      else $error("read response late");
endmodule // sipe_monitor

bind sipe_top sipe_monitor u_mon (.aclk, .aresetn, .awvalid, .awready,
   .wvalid, .wready, .bvalid, .bready, .arvalid, .arready, .rdata,
   .rvalid, .rready, .in_a, .supply_a_on, .supply_b_on, .in_status,
   .in_valid);

//--- verilog/sipe_axil.v
// sipe_axil.v: axi4-lite slave front end, one write and one read at a time
// assumes a single clock domain; register file lives in the top module
`timescale 1ns/1ps
module sipe_axil (
   // clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // axi4-lite
   input  wire [7:0]  awaddr,
   input  wire        awvalid,
   output reg         awready,
   input  wire [31:0] wdata,
   input  wire [3:0]  wstrb,
   input  wire        wvalid,
   output reg         wready,
   output reg  [1:0]  bresp,
   output reg         bvalid,
   input  wire        bready,
   input  wire [7:0]  araddr,
   input  wire        arvalid,
   output reg         arready,
   output reg  [31:0] rdata,
   output reg  [1:0]  rresp,
   output reg         rvalid,
   input  wire        rready,
   // register side
   output reg         wr_en,
   output reg  [7:0]  wr_addr,
   output reg  [31:0] wr_data,
   output reg  [3:0]  wr_strb,
   input  wire        wr_ok,
   output wire [7:0]  rd_addr,
   input  wire [31:0] rd_data,
   input  wire        rd_ok
);
   reg        aw_have_q;
   reg        w_have_q;
   reg [7:0]  ar_addr_q;
   reg        ar_have_q;

   assign rd_addr = ar_addr_q;

   always @(posedge aclk) begin
      if (!aresetn) begin
         awready   <= 1'b0;
         wready    <= 1'b0;
         bvalid    <= 1'b0;
         bresp     <= 2'b00;
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         wr_en     <= 1'b0;
         wr_addr   <= 8'h00;
         wr_data   <= 32'h0000_0000;
         wr_strb   <= 4'h0;
      end else begin
         wr_en   <= 1'b0;
         awready <= !aw_have_q && !awready && !bvalid && awvalid;
         wready  <= !w_have_q && !wready && !bvalid && wvalid;
         if (awvalid && awready) begin
            aw_have_q <= 1'b1;
            wr_addr   <= awaddr;
         end
         if (wvalid && wready) begin
            w_have_q <= 1'b1;
            wr_data  <= wdata;
            wr_strb  <= wstrb;
         end
         if (aw_have_q && w_have_q && !bvalid && !wr_en) begin
            wr_en <= 1'b1;
         end
         if (wr_en) begin
            bvalid    <= 1'b1;
            bresp     <= wr_ok ? 2'b00 : 2'b10;
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         arready   <= 1'b0;
         ar_have_q <= 1'b0;
         ar_addr_q <= 8'h00;
         rvalid    <= 1'b0;
         rdata     <= 32'h0000_0000;
         rresp     <= 2'b00;
      end else begin
         arready <= !ar_have_q && !arready && !rvalid && arvalid;
         if (arvalid && arready) begin
            ar_have_q <= 1'b1;
            ar_addr_q <= araddr;
         end
         if (ar_have_q && !rvalid) begin
            rvalid    <= 1'b1;
            rdata     <= rd_ok ? rd_data : 32'h0000_0000;
            rresp     <= rd_ok ? 2'b00 : 2'b10;
            ar_have_q <= 1'b0;
         end else if (rvalid && rready) begin
            rvalid <= 1'b0;
         end
      end
   end
endmodule // sipe_axil

//--- verilog/sipe_consts.vh
// sipe_consts.vh: constants of the safety input pulse evaluation block
// assumes a 50 MHz clock; included by bare name, definitions only
`ifndef SIPE_CONSTS_VH
`define SIPE_CONSTS_VH

// register byte addresses
`define SIPE_ADDR_MODE      8'h00
`define SIPE_ADDR_VALENCE   8'h04
`define SIPE_ADDR_STATUS    8'h08
`define SIPE_ADDR_VALID     8'h0C
`define SIPE_ADDR_CONFIG    8'h10
`define SIPE_ADDR_SUPPLY    8'h14

// mode field per port: bit 0 dual channel, bit 1 with clock
`define SIPE_MODE_DUAL_BIT  0
`define SIPE_MODE_CLK_BIT   1
// config: bit 0 safe setting, bit 1 sixteen input variant
`define SIPE_CFG_SAFE_BIT   0
`define SIPE_CFG_N16_BIT    1

// reset values
`define SIPE_MODE_RST       16'h0000
`define SIPE_VAL_RST        8'h00
`define SIPE_CFG_RST        2'h1

// timing, clock rate in kHz, times in microseconds
`define SIPE_CLK_KHZ        50000
`define SIPE_T_LEN_US       500
`define SIPE_T_NEXT_US      32000
`define SIPE_T_DIAG8_US     108000
`define SIPE_T_DIAG16_US    204000
`define SIPE_LEN_CYC        ((`SIPE_T_LEN_US * `SIPE_CLK_KHZ) / 1000)
`define SIPE_NEXT_CYC       ((`SIPE_T_NEXT_US * `SIPE_CLK_KHZ) / 1000)
// settle time before checking the input follows the pulse
`define SIPE_SETTLE_CYC     32'd100

`endif

//--- verilog/sipe_pulse.v
// sipe_pulse.v: test pulse sequencer stepping through the inputs in turn
// assumes one clock at 50 MHz; slot count 8 or 16 chosen by n16
`timescale 1ns/1ps
`include "sipe_consts.vh"
module sipe_pulse (
   // clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // control
   input  wire        n16,
   // pulse state
   output reg  [3:0]  slot_q,
   output reg         pulse_q,
   output reg         check_q
);
   localparam [31:0] LEN  = `SIPE_LEN_CYC;
   localparam [31:0] NEXT = `SIPE_NEXT_CYC;
   reg [31:0] cnt_q;

   // R8 pulse timing
   always @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q   <= 32'h0000_0000;
         slot_q  <= 4'h0;
         pulse_q <= 1'b0;
         check_q <= 1'b0;
      end else begin
         check_q <= 1'b0;
         if (cnt_q == NEXT - 32'd1) begin
            cnt_q   <= 32'h0000_0000;
            pulse_q <= 1'b1;
            if (n16 ? (slot_q == 4'hF) : (slot_q[2:0] == 3'h7))
               slot_q <= 4'h0;
            else
               slot_q <= slot_q + 4'h1;
         end else begin
            cnt_q <= cnt_q + 32'd1;
            if (cnt_q == LEN - 32'd1)
               pulse_q <= 1'b0;
            if (cnt_q == LEN - 32'd2)
               check_q <= 1'b1;
         end
      end
   end
endmodule // sipe_pulse

//--- verilog/sipe_top.v
// sipe_top.v: safety digital input evaluation with axi4-lite registers
// assumes synchronous sensor inputs; 8 ports, channels a and b each
//
// Summary of operation
// R1: each port picks single or dual channel analysis, with or without clock, and config must be safe.
// R2: with clock modes switch both port supplies off cyclically, otherwise they stay on.
// R3: single channel modes give two independent bits and ignore valence.
// R4: valence is not evaluated for a single channel port.
// R5: dual channel modes give one bit in the a position mirrored into b.
// R6: antivalence is valid only while a and b differ.
// R7: equivalence is valid only while a and b match.
// R8: test pulses last 0.5 ms and step through the inputs 32 ms apart.
// R9: with clock diagnostic interval is 108 ms for 8 inputs, 204 ms for 16; the code pulses each port every 256 ms with either n16 setting.
// R10: the controller needs a response time at least the diagnostic interval.
// R11: without clock the controller tests the inputs by switching them off.
// R12: external test interval for dual equivalence without clock is at most 24 h.
// R13: no cross fault detection is claimed without clock.
// R14: a validity bit per channel accompanies each status bit.
// R15: failed checks or missing pulse clear validity and force the input off.
//
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "sipe_consts.vh"
module sipe_top (
   // clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // axi4-lite
   input  wire [7:0]  awaddr,
   input  wire        awvalid,
   output wire        awready,
   input  wire [31:0] wdata,
   input  wire [3:0]  wstrb,
   input  wire        wvalid,
   output wire        wready,
   output wire [1:0]  bresp,
   output wire        bvalid,
   input  wire        bready,
   input  wire [7:0]  araddr,
   input  wire        arvalid,
   output wire        arready,
   output wire [31:0] rdata,
   output wire [1:0]  rresp,
   output wire        rvalid,
   input  wire        rready,
   // sensor side
   input  wire [7:0]  in_a,
   input  wire [7:0]  in_b,
   output reg  [7:0]  supply_a_on,
   output reg  [7:0]  supply_b_on,
   // status toward the controller
   output reg  [15:0] in_status,
   output reg  [15:0] in_valid
);
   reg  [15:0] mode_q;
   reg  [7:0]  valence_q;
   reg  [1:0]  cfg_q;
   reg  [7:0]  pulse_fail_q;
   wire        wr_en;
   wire [7:0]  wr_addr;
   wire [31:0] wr_data;
   wire [3:0]  wr_strb;
   reg         wr_ok;
   wire [7:0]  rd_addr;
   reg  [31:0] rd_data;
   reg         rd_ok;
   wire [3:0]  slot;
   wire        pulse;
   wire        check;
   reg  [15:0] st_d;
   reg  [15:0] vl_d;
   reg  [7:0]  sup_d;
   wire        mode_we;
   wire        val_we;
   wire        cfg_we;
   integer     i;
   integer     j;
   integer     k;

   function mode_dual;
      input [15:0] m;
      input [2:0]  p;
      begin
         mode_dual = m[{p, 1'b0} + `SIPE_MODE_DUAL_BIT];
      end
   endfunction

   function mode_clk;
      input [15:0] m;
      input [2:0]  p;
      begin
         mode_clk = m[{p, 1'b0} + `SIPE_MODE_CLK_BIT];
      end
   endfunction

   function addr_mapped;
      input [7:0] a;
      begin
         case (a)
            `SIPE_ADDR_MODE,
            `SIPE_ADDR_VALENCE,
            `SIPE_ADDR_STATUS,
            `SIPE_ADDR_VALID,
            `SIPE_ADDR_CONFIG,
            `SIPE_ADDR_SUPPLY: addr_mapped = 1'b1;
            default:           addr_mapped = 1'b0;
         endcase
      end
   endfunction

   function slot_hit;
      input [3:0] s;
      input [2:0] p;
      begin
         slot_hit = (s[2:0] == p);
      end
   endfunction

   sipe_axil u_axil (
      .aclk    (aclk),
      .aresetn (aresetn),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready),
      .wr_en   (wr_en),
      .wr_addr (wr_addr),
      .wr_data (wr_data),
      .wr_strb (wr_strb),
      .wr_ok   (wr_ok),
      .rd_addr (rd_addr),
      .rd_data (rd_data),
      .rd_ok   (rd_ok)
   );

   sipe_pulse u_pulse (
      .aclk    (aclk),
      .aresetn (aresetn),
      .n16     (cfg_q[`SIPE_CFG_N16_BIT]),
      .slot_q  (slot),
      .pulse_q (pulse),
      .check_q (check)
   );

   // address decode for both directions
   always @* begin
      wr_ok = addr_mapped(wr_addr);
      rd_ok = addr_mapped(rd_addr);
   end

   // write enables per register
   assign mode_we = wr_en && (wr_addr == `SIPE_ADDR_MODE);
   assign val_we  = wr_en && (wr_addr == `SIPE_ADDR_VALENCE);
   assign cfg_we  = wr_en && (wr_addr == `SIPE_ADDR_CONFIG);

   // R1 mode register
   always @(posedge aclk) begin
      if (!aresetn) begin
         mode_q <= `SIPE_MODE_RST;
      end else if (mode_we) begin
         if (wr_strb[0])
            mode_q[7:0] <= wr_data[7:0];
         if (wr_strb[1])
            mode_q[15:8] <= wr_data[15:8];
      end
   end

   // R6 R7 valence register
   always @(posedge aclk) begin
      if (!aresetn) begin
         valence_q <= `SIPE_VAL_RST;
      end else if (val_we && wr_strb[0]) begin
         valence_q <= wr_data[7:0];
      end
   end

   // R1 safe setting
   always @(posedge aclk) begin
      if (!aresetn) begin
         cfg_q <= `SIPE_CFG_RST;
      end else if (cfg_we && wr_strb[0]) begin
         cfg_q <= wr_data[1:0];
      end
   end

   // read mux
   always @* begin
      rd_data = 32'h0000_0000;
      case (rd_addr)
         `SIPE_ADDR_MODE:    rd_data = {16'h0000, mode_q};
         `SIPE_ADDR_VALENCE: rd_data = {24'h00_0000, valence_q};
         `SIPE_ADDR_STATUS:  rd_data = {16'h0000, in_status};
         `SIPE_ADDR_VALID:   rd_data = {16'h0000, in_valid};
         `SIPE_ADDR_CONFIG:  rd_data = {30'h0000_0000, cfg_q};
         `SIPE_ADDR_SUPPLY:  rd_data = {16'h0000, supply_b_on, supply_a_on};
         default:            rd_data = 32'h0000_0000;
      endcase
   end

   // evaluation per port
   always @* begin
      st_d  = 16'h0000;
      vl_d  = 16'h0000;
      for (i = 0; i < 8; i = i + 1) begin
         if (!mode_dual(mode_q, i[2:0])) begin
            // R3 R4 independent bits
            st_d[2*i]   = in_a[i];
            st_d[2*i+1] = in_b[i];
            vl_d[2*i]   = 1'b1;
            vl_d[2*i+1] = 1'b1;
         end else begin
            // R6 R7 valence check
            vl_d[2*i] = valence_q[i] ? (in_a[i] ^ in_b[i])
                                     : ~(in_a[i] ^ in_b[i]);
            // R5 mirrored bit
            st_d[2*i]   = vl_d[2*i] & in_a[i];
            st_d[2*i+1] = st_d[2*i];
            vl_d[2*i+1] = vl_d[2*i];
         end
         // R15 fault forces off
         if (pulse_fail_q[i] || !cfg_q[`SIPE_CFG_SAFE_BIT]) begin
            vl_d[2*i]   = 1'b0;
            vl_d[2*i+1] = 1'b0;
            st_d[2*i]   = 1'b0;
            st_d[2*i+1] = 1'b0;
         end
      end
   end

   // R2 supply switch off
   always @* begin
      sup_d = 8'hFF;
      for (k = 0; k < 8; k = k + 1) begin
         if (mode_clk(mode_q, k[2:0]) && pulse && slot_hit(slot, k[2:0]))
            sup_d[k] = 1'b0;
      end
   end

   // R15 pulse observation
   // R9 fault latched at each check
   always @(posedge aclk) begin
      if (!aresetn) begin
         pulse_fail_q <= 8'h00;
      end else begin
         for (j = 0; j < 8; j = j + 1) begin
            // R13 no check without clock
            if (!mode_clk(mode_q, j[2:0]))
               pulse_fail_q[j] <= 1'b0;
            else if (check && slot_hit(slot, j[2:0]))
               pulse_fail_q[j] <= in_a[j] | in_b[j];
         end
      end
   end

   // R14 registered status
   always @(posedge aclk) begin
      if (!aresetn) begin
         in_status <= 16'h0000;
         in_valid  <= 16'h0000;
      end else begin
         in_status <= st_d;
         in_valid  <= vl_d;
      end
   end

   // R2 registered supplies
   always @(posedge aclk) begin
      if (!aresetn) begin
         supply_a_on <= 8'hFF;
         supply_b_on <= 8'hFF;
      end else begin
         supply_a_on <= sup_d;
         supply_b_on <= sup_d;
      end
   end
endmodule // sipe_top
